/* File: rtl/tpss_status_sense.v */
// Status and sense byte logic of a serial teleprinter line adapter.
// Assumes the line datapath and the shared_adapter_common unit deliver
// one-cycle event pulses synchronous to core_clk.
//
// Functional notes
// - Poll end with modifier means read/write next.
// - Bad poll response sets modifier plus unit check.
// - Read cancel sets modifier plus unit exception.
// - Channel end and device end always together.
// - Unit check at selection and ending errors.
// - Zero count (write/read) or halt sets unit exception; halt in test does not.
// - Valid poll/write/read/test clears sense byte.
// - Undefined good-parity command sets command reject.
// - Undefined device response sets intervention required.
// - Common unit bus-out error sets sense bit 2.
// - Selection bus-out error keeps only that bit.
// - Bus-out error in poll/first write terminates.
// - Write-text bus-out error continues, inverts LRC.
// - Echo faults set sense bit 3, terminate.
// - Data parity error sets data check.
// - Poll data parity error ends poll immediately.
// - Read overrun sets sense bit 5, terminates.
// - Three second wait timeout sets timeout bit.
// - Eighteen second read waits report timeout.
// - LRC negative reply or miscompare sets bit 7.
// - Lower adapter address gets higher priority.
// - Status accepted by channel clears status.
// - Status presented at selection, end, stacked.
`timescale 1ns/100ps
`include "tpss_consts.vh"
module tpss_status_sense #(
    parameter [31:0] SHORT_CYC = `TPSS_SHORT_TO_CYC,
    parameter [31:0] LONG_CYC = `TPSS_LONG_TO_CYC,
    parameter [3:0] MY_ADDR = 4'h0
) (
    input wire core_clk,
    input wire resetn,
    // Command decode from initial selection
    input wire cmd_valid,
    input wire cmd_parity_ok,
    input wire cmd_defined,
    input wire cmd_is_start,
    input wire cmd_is_noop,
    input wire cmd_is_sense,
    // Operation state from the sequencer
    input wire op_poll,
    input wire op_write,
    input wire op_read,
    input wire op_test,
    input wire write_text,
    input wire poll_is_input,
    // Line and channel events
    input wire bus_out_err,
    input wire data_par_err,
    input wire poll_resp_bad,
    input wire resp_undefined,
    input wire echo_err,
    input wire overrun_err,
    input wire lrc_neg_reply,
    input wire lrc_cmp_fail,
    input wire cancel_done,
    input wire count_zero,
    input wire halt_io,
    input wire normal_end,
    input wire sense_accepted,
    input wire status_accepted,
    input wire stack_allowed,
    // Timeout control
    input wire [1:0] wait_mode,
    input wire wait_restart,
    // Service priority
    input wire [15:0] req_group,
    // Outputs
    output reg [8:0] status_byte_ff,
    output reg [8:0] sense_byte_ff,
    output wire status_present,
    output reg op_end_ff,
    output reg next_is_write_ff,
    output reg invert_lrc_ff,
    output reg force_bit0_zero_ff,
    output wire grant_mine
);
    // Reset release is synchronised so that every flop leaves reset on
    // the same edge; the raw pin only enters the two synchroniser stages
    reg rst_sync1_ff; // Reset synchroniser first stage
    reg rst_sync2_ff; // Synchronised reset
    wire rst_n = rst_sync2_ff;
    reg [7:0] status_ff; // Status bits
    reg [7:0] sense_ff; // Sense bits
    reg pending_ff; // Status waiting to be accepted
    reg deferred_uc_ff; // Unit check owed at next end
    // Next-state values; one combinational process makes all of them,
    // so each register has a single driver
    reg [7:0] nxt_status_ff;
    reg [7:0] nxt_sense_ff;
    reg nxt_pending_ff;
    reg nxt_deferred_uc_ff;
    reg nxt_op_end_ff;
    reg nxt_next_is_write_ff;
    reg nxt_invert_lrc_ff;
    reg nxt_force_bit0_zero_ff;
    // Decoded conditions shared by the next-state process
    // Line wait ran out: one-cycle pulse from the timer
    wire timeout;
    wire in_op = op_poll | op_write | op_read | op_test;
    wire error_end; // Errors that end the operation with unit check
    wire sel_reject;
    wire sel_busout;

    // Reset release through two flip-flops
    // Assert at once, release on the second edge after the pin rises
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end

    // Line timeout counter, short or long wait; the sequencer picks the
    // wait and restarts it on every awaited character, so only a silent
    // line lets it run out
    tpss_line_timer #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) tpss_line_timer_inst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode(wait_mode),
        .restart(wait_restart),
        .expired_ff(timeout)
    );

    // Selection-time checks; a bus-out error outranks command reject,
    // because a command with bad bus parity cannot be trusted to decode
    assign sel_busout = cmd_valid & bus_out_err;
    assign sel_reject = cmd_valid & ~bus_out_err & cmd_parity_ok & ~cmd_defined;

    // Terminating errors during an operation
    // Write text tolerates bus-out and data errors, which only owe unit
    // check at the ending; everything here stops the operation at once
    assign error_end = in_op & (resp_undefined
        | echo_err
        | (op_read & overrun_err)
        | timeout
        | (bus_out_err & (op_poll | (op_write & ~write_text)))
        | (op_poll & (data_par_err | poll_resp_bad))
        | (op_write & lrc_neg_reply) | (op_read & lrc_cmp_fail));

    // Status and sense next state
    // Order matters: acceptance clears first, selection decodes next,
    // then error bits and terminations, so that a set in the same
    // cycle as a clear wins and no event is lost
    always @* begin
        nxt_status_ff = status_ff;
        nxt_sense_ff = sense_ff;
        nxt_pending_ff = pending_ff;
        nxt_deferred_uc_ff = deferred_uc_ff;
        nxt_op_end_ff = 1'b0;
        nxt_next_is_write_ff = next_is_write_ff;
        nxt_invert_lrc_ff = invert_lrc_ff;
        nxt_force_bit0_zero_ff = 1'b0;
        // Status accepted clears it; a new set below wins
        if (status_accepted) begin
            nxt_status_ff = 8'h00;
            nxt_pending_ff = 1'b0;
        end
        if (sel_busout) begin
            // Command ignored; sense keeps only bus-out
            nxt_sense_ff = 8'h00;
            nxt_sense_ff[`TPSS_SN_BOUT] = 1'b1;
            nxt_status_ff[`TPSS_ST_UC] = 1'b1;
            nxt_pending_ff = 1'b1;
        end else if (sel_reject) begin
            // Undefined command: sense is left holding only command reject,
            // and the command itself is never started
            nxt_sense_ff = 8'h00;
            nxt_sense_ff[`TPSS_SN_CREJ] = 1'b1;
            nxt_status_ff[`TPSS_ST_UC] = 1'b1;
            nxt_pending_ff = 1'b1;
        end else if (cmd_valid && cmd_is_start) begin
            // New operation: fresh sense byte, no owed unit check and an
            // LRC that is no longer inverted
            nxt_sense_ff = 8'h00;
            nxt_deferred_uc_ff = 1'b0;
            nxt_invert_lrc_ff = 1'b0;
        end else if (cmd_valid && cmd_is_noop) begin
            // Null control command does nothing but end at selection,
            // so its status comes straight back
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            nxt_pending_ff = 1'b1;
        end
        // Sense byte taken by the channel ends the sense command
        if (cmd_is_sense && sense_accepted) begin
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            nxt_pending_ff = 1'b1;
        end
        // Common unit bus-out error is always recorded
        if (bus_out_err && !cmd_valid) begin
            nxt_sense_ff[`TPSS_SN_BOUT] = 1'b1;
        end

        // Sense bits for operation errors; several may land together,
        // while the status byte shows a single ending for all of them
        if (in_op) begin
            if (resp_undefined) begin
                nxt_sense_ff[`TPSS_SN_INTV] = 1'b1;
            end
            if (echo_err) begin
                nxt_sense_ff[`TPSS_SN_ECHO] = 1'b1;
            end
            if (data_par_err || (op_poll && poll_resp_bad)) begin
                nxt_sense_ff[`TPSS_SN_DATA] = 1'b1;
            end
            if (op_read && overrun_err) begin
                nxt_sense_ff[`TPSS_SN_OVRN] = 1'b1;
            end
            if (timeout) begin
                nxt_sense_ff[`TPSS_SN_TOUT] = 1'b1;
            end
            if ((op_write && lrc_neg_reply) || (op_read && lrc_cmp_fail)) begin
                nxt_sense_ff[`TPSS_SN_LRC] = 1'b1;
            end
        end

        // Non-fatal text errors owe unit check at the end; a parity error
        // on a first write byte is not fatal either, so it owes one too
        if ((op_write && write_text && bus_out_err) || ((op_write || op_read) && data_par_err)) begin
            nxt_deferred_uc_ff = 1'b1;
        end
        // Write text errors invert the LRC before it is sent
        if (op_write && write_text && (bus_out_err || data_par_err)) begin
            nxt_invert_lrc_ff = 1'b1;
        end
        // Read parity error forces byte bit 0 low
        if (op_read && data_par_err) begin
            nxt_force_bit0_zero_ff = 1'b1;
        end

        // Terminations, priority: error, halt/count, cancel, normal
        // Only one ending is taken per cycle; an error ending also covers
        // a halt or a zero count in the same cycle, as unit check says more
        if (error_end) begin
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            nxt_status_ff[`TPSS_ST_UC] = 1'b1;
            if (op_poll && poll_resp_bad) begin
                nxt_status_ff[`TPSS_ST_MOD] = 1'b1;
            end
            nxt_pending_ff = 1'b1;
            nxt_op_end_ff = 1'b1;
        end else if (in_op && (halt_io || (count_zero && (op_write || op_read)))) begin
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            if (!op_test) begin
                nxt_status_ff[`TPSS_ST_UE] = 1'b1;
            end
            // Owed check includes a text error of this very cycle
            nxt_status_ff[`TPSS_ST_UC] = nxt_deferred_uc_ff | nxt_status_ff[`TPSS_ST_UC];
            nxt_pending_ff = 1'b1;
            nxt_op_end_ff = 1'b1;
        end else if (op_read && cancel_done) begin
            // Cancel passed to the channel: the host should poll again,
            // so this ending carries the modifier with unit exception
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            nxt_status_ff[`TPSS_ST_MOD] = 1'b1;
            nxt_status_ff[`TPSS_ST_UE] = 1'b1;
            nxt_pending_ff = 1'b1;
            nxt_op_end_ff = 1'b1;
        end else if (in_op && normal_end) begin
            // Clean ending; text errors of the operation still owe their
            // unit check, which is folded in here
            nxt_status_ff[`TPSS_ST_CE] = 1'b1;
            nxt_status_ff[`TPSS_ST_DE] = 1'b1;
            // Owed check includes a text error of this very cycle
            nxt_status_ff[`TPSS_ST_UC] = nxt_deferred_uc_ff | nxt_status_ff[`TPSS_ST_UC];
            if (op_poll) begin
                // Service request: modifier says issue read or write
                nxt_status_ff[`TPSS_ST_MOD] = 1'b1;
                nxt_next_is_write_ff = ~poll_is_input;
            end
            nxt_pending_ff = 1'b1;
            nxt_op_end_ff = 1'b1;
        end

        // The owed check is spent by this ending
        if (nxt_op_end_ff) begin
            nxt_deferred_uc_ff = 1'b0;
        end
    end

    // State registers; bytes carry odd parity in bit 8
    // The parity is formed from the next-state value, so each byte and
    // its parity bit always change on the same edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= `TPSS_STATUS_RST;
            sense_ff <= `TPSS_SENSE_RST;
            pending_ff <= 1'b0;
            deferred_uc_ff <= 1'b0;
            op_end_ff <= 1'b0;
            next_is_write_ff <= 1'b0;
            invert_lrc_ff <= 1'b0;
            force_bit0_zero_ff <= 1'b0;
            status_byte_ff <= 9'h100;
            sense_byte_ff <= 9'h100;
        end else begin
            status_ff <= nxt_status_ff;
            sense_ff <= nxt_sense_ff;
            pending_ff <= nxt_pending_ff;
            deferred_uc_ff <= nxt_deferred_uc_ff;
            op_end_ff <= nxt_op_end_ff;
            next_is_write_ff <= nxt_next_is_write_ff;
            invert_lrc_ff <= nxt_invert_lrc_ff;
            force_bit0_zero_ff <= nxt_force_bit0_zero_ff;
            status_byte_ff <= {~(^nxt_status_ff), nxt_status_ff};
            sense_byte_ff <= {~(^nxt_sense_ff), nxt_sense_ff};
        end
    end

    // Status offered at selection, end, or when stacking is allowed
    // Combinational so the channel sees it in the same cycle as the
    // ending pulse; pending_ff alone decides whether there is status
    assign status_present = pending_ff & (stack_allowed | cmd_valid | op_end_ff);

    // Fixed priority: lowest requesting address in the group wins
    // Each bit of the chain says that some lower address is asking; the
    // chain is built bit by bit so the group width stays in one place
    wire [15:0] lower_req; // Some lower address is requesting
    genvar gi;
    assign lower_req[0] = 1'b0;
    generate
        for (gi = 1; gi < 16; gi = gi + 1) begin : g_prio_chain
            assign lower_req[gi] = lower_req[gi-1] | req_group[gi-1];
        end
    endgenerate
    assign grant_mine = req_group[MY_ADDR] & ~lower_req[MY_ADDR];
endmodule

/* File: include/tpss_consts.vh */
// Constants for the teleprinter adapter status and sense logic.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef TPSS_CONSTS_VH
`define TPSS_CONSTS_VH
// Status byte bit positions
`define TPSS_ST_MOD 6
`define TPSS_ST_CE 3
`define TPSS_ST_DE 2
`define TPSS_ST_UC 1
`define TPSS_ST_UE 0
// Sense byte bit positions
`define TPSS_SN_CREJ 7
`define TPSS_SN_INTV 6
`define TPSS_SN_BOUT 5
`define TPSS_SN_ECHO 4
`define TPSS_SN_DATA 3
`define TPSS_SN_OVRN 2
`define TPSS_SN_TOUT 1
`define TPSS_SN_LRC 0
// Reset values
`define TPSS_STATUS_RST 8'h00
`define TPSS_SENSE_RST 8'h00
// Timing
`define TPSS_CLK_HZ 25000000
`define TPSS_SHORT_TO_S 3
`define TPSS_LONG_TO_S 18
`define TPSS_SHORT_TO_CYC (`TPSS_SHORT_TO_S * `TPSS_CLK_HZ)
`define TPSS_LONG_TO_CYC (`TPSS_LONG_TO_S * `TPSS_CLK_HZ)
// Timeout selector codes
`define TPSS_TO_OFF 2'h0
`define TPSS_TO_SHORT 2'h1
`define TPSS_TO_LONG 2'h2
`endif

/* File: rtl/tpss_line_timer.v */
// Line timeout counter for the teleprinter adapter status logic.
// Assumes the caller restarts it on every awaited line event.
`timescale 1ns/100ps
`include "tpss_consts.vh"
module tpss_line_timer #(
    parameter [31:0] SHORT_CYC = `TPSS_SHORT_TO_CYC,
    parameter [31:0] LONG_CYC = `TPSS_LONG_TO_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire [1:0] mode,
    input wire restart,
    output reg expired_ff
);
    reg [31:0] count_ff; // Cycles elapsed in the current wait
    reg [31:0] limit; // Limit for the selected wait
    reg [31:0] nxt_count_ff;
    reg nxt_expired_ff;

    // Limit select
    always @* begin
        case (mode)
            `TPSS_TO_SHORT: limit = SHORT_CYC;
            `TPSS_TO_LONG: limit = LONG_CYC;
            default: limit = 32'h0;
        endcase
    end

    // Count while armed; one-cycle expiry pulse at the limit
    always @* begin
        nxt_count_ff = count_ff;
        nxt_expired_ff = 1'b0;
        if (restart || mode == `TPSS_TO_OFF) begin
            nxt_count_ff = 32'h0;
        end else if (count_ff == limit - 32'h1) begin
            nxt_expired_ff = 1'b1;
            nxt_count_ff = 32'h0;
        end else begin
            nxt_count_ff = count_ff + 32'h1;
        end
    end

    // Registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 32'h0;
            expired_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count_ff;
            expired_ff <= nxt_expired_ff;
        end
    end
endmodule

/* File: test/tpss_checker.sv */
// Concurrent checks on the status and sense byte logic.
// Bound to tpss_status_sense; sees only its ports.
`timescale 1ns/100ps
module tpss_checker #(
    parameter [3:0] MY_ADDR = 4'h0
) (
    input wire core_clk,
    input wire resetn,
    input wire cmd_valid,
    input wire cmd_parity_ok,
    input wire cmd_defined,
    input wire op_write,
    input wire op_read,
    input wire bus_out_err,
    input wire echo_err,
    input wire overrun_err,
    input wire lrc_neg_reply,
    input wire cancel_done,
    input wire [15:0] req_group,
    input wire [8:0] status_byte_ff,
    input wire [8:0] sense_byte_ff,
    input wire op_end_ff,
    input wire grant_mine
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Read cancel and write negative answer, each a one-step cause
    sequence s_cancel;
        op_read && cancel_done;
    endsequence
    sequence s_lrc_neg;
        op_write && lrc_neg_reply;
    endsequence
    AST_ST_PAR: assert property (status_byte_ff[8] == ~^status_byte_ff[7:0])
        else $error("status parity bad");
    AST_SN_PAR: assert property (sense_byte_ff[8] == ~^sense_byte_ff[7:0])
        else $error("sense parity bad");
    AST_CE_DE: assert property (status_byte_ff[3] == status_byte_ff[2])
        else $error("ends apart");
    AST_END_ST: assert property (op_end_ff |-> status_byte_ff[3] && status_byte_ff[2])
        else $error("end without status");
    AST_REJECT: assert property (cmd_valid && cmd_parity_ok && !cmd_defined && !bus_out_err
        |=> sense_byte_ff[7:0] == 8'h80 && status_byte_ff[1]) else $error("reject wrong");
    AST_BOUT_SEL: assert property (cmd_valid && bus_out_err
        |=> sense_byte_ff[7:0] == 8'h20 && status_byte_ff[1]) else $error("bus-out select wrong");
    AST_ECHO: assert property (op_write && echo_err |=> sense_byte_ff[4] && op_end_ff)
        else $error("echo not ended");
    AST_OVRN: assert property (op_read && overrun_err |=> sense_byte_ff[2] && status_byte_ff[1])
        else $error("overrun wrong");
    AST_LRC: assert property (s_lrc_neg |=> sense_byte_ff[0] && op_end_ff)
        else $error("lrc not flagged");
    AST_CANCEL: assert property (s_cancel |=> status_byte_ff[6] && status_byte_ff[0])
        else $error("cancel status wrong");
    AST_GRANT: assert property (grant_mine == (req_group[MY_ADDR]
        && (req_group & ((16'h1 << MY_ADDR) - 16'h1)) == 16'h0)) else $error("priority wrong");
endmodule
bind tpss_status_sense tpss_checker #(.MY_ADDR(MY_ADDR)) tpss_checker_inst (
    .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_parity_ok(cmd_parity_ok),
    .cmd_defined(cmd_defined), .op_write(op_write), .op_read(op_read), .bus_out_err(bus_out_err),
    .echo_err(echo_err), .overrun_err(overrun_err), .lrc_neg_reply(lrc_neg_reply),
    .cancel_done(cancel_done), .req_group(req_group), .status_byte_ff(status_byte_ff),
    .sense_byte_ff(sense_byte_ff), .op_end_ff(op_end_ff), .grant_mine(grant_mine));

/* File: test/tpss_chan_model.sv */
// Channel-side model that takes presented status.
// Assumes status_present is a level from the adapter.
`timescale 1ns/100ps
module tpss_chan_model (
    input wire core_clk,
    input wire resetn,
    input wire status_present,
    input wire accept_en,
    input wire slow,
    output reg status_accepted
);
    reg [2:0] wait_ff; // Pause before taking status
    // One acceptance pulse, after a short or a long pause
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_ff <= 3'h0;
            status_accepted <= 1'b0;
        end else if (status_accepted || !status_present || !accept_en) begin
            wait_ff <= 3'h0;
            status_accepted <= 1'b0;
        end else if (wait_ff >= (slow ? 3'h4 : 3'h0)) begin
            status_accepted <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the status and sense byte logic.
// Assumes a 25 MHz clock and the channel model taking status.
`timescale 1ns/100ps
module tb_top;
    localparam [31:0] SC = 32'h14;
    localparam [31:0] LC = 32'h32;
    localparam [7:0] M = 8'h40; // Status modifier
    localparam [7:0] E = 8'h0c; // Channel end and device end
    localparam [7:0] C = 8'h02; // Unit check
    localparam [7:0] X = 8'h01; // Unit exception
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg [14:0] ev = 15'h0; // Event pulses
    reg [4:0] cm = 5'h0; // Command decode levels
    reg [3:0] op = 4'h0; // Operation levels
    reg wtx = 1'b0, pin = 1'b0, slow = 1'b0, acc_en = 1'b0, stk = 1'b1; // Levels, stacking allowed
    reg [1:0] wm = 2'h0;
    reg [15:0] req = 16'h0;
    reg [31:0] rs = 32'h31; // Random state, seed 49
    reg [7:0] sn_m = 8'h0; // Sense model
    integer failures = 0, tests_run = 0, n = 0, k;
    wire [8:0] st_b, sn_b;
    wire present, acc, op_end, nxt_wr, grant, inv_l, f0z;
    tpss_status_sense #(.SHORT_CYC(SC), .LONG_CYC(LC), .MY_ADDR(4'h5)) tpss_status_sense_inst (
        .core_clk(core_clk), .resetn(resetn), .cmd_valid(ev[13]), .cmd_parity_ok(cm[0]),
        .cmd_defined(cm[1]), .cmd_is_start(cm[2]), .cmd_is_noop(cm[3]), .cmd_is_sense(cm[4]),
        .op_poll(op[0]), .op_write(op[1]), .op_read(op[2]), .op_test(op[3]), .write_text(wtx),
        .poll_is_input(pin), .bus_out_err(ev[0]), .data_par_err(ev[1]), .poll_resp_bad(ev[2]),
        .resp_undefined(ev[3]), .echo_err(ev[4]), .overrun_err(ev[5]), .lrc_neg_reply(ev[6]),
        .lrc_cmp_fail(ev[7]), .cancel_done(ev[8]), .count_zero(ev[9]), .halt_io(ev[10]),
        .normal_end(ev[11]), .sense_accepted(ev[12]), .status_accepted(acc), .stack_allowed(stk),
        .wait_mode(wm), .wait_restart(ev[14]), .req_group(req), .status_byte_ff(st_b),
        .sense_byte_ff(sn_b), .status_present(present), .op_end_ff(op_end),
        .next_is_write_ff(nxt_wr), .invert_lrc_ff(inv_l), .force_bit0_zero_ff(f0z), .grant_mine(grant));
    tpss_chan_model tpss_chan_model_inst (.core_clk(core_clk), .resetn(resetn),
        .status_present(present), .accept_en(acc_en), .slow(slow), .status_accepted(acc));
    // Clock of 40 ns
    always #20 core_clk = ~core_clk;
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Byte with odd parity on top
    function [8:0] par(input [7:0] b);
        par = {~^b, b};
    endfunction
    task tick;
        begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task chk(input [8:0] seen, input [8:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One cycle of events; returns just after the sampling edge
    task pulse(input [14:0] e);
        begin
            ev = e;
            tick;
            ev = 15'h0;
        end
    endtask
    // Channel takes the status, which must then read cleared
    task accept;
        begin
            chk({8'h0, present}, {8'h0, st_b[7:0] != 8'h00});
            stk = 1'b0;
            tick;
            chk({8'h0, present}, 9'h0);
            stk = 1'b1;
            rs = xs(rs);
            slow = rs[0];
            acc_en = 1'b1;
            k = 0;
            while (st_b !== 9'h100 && k < 12) begin
                tick;
                k = k + 1;
            end
            acc_en = 1'b0;
            chk(st_b, 9'h100);
        end
    endtask
    // Start an operation if o is set, apply events, compare with the model
    task run(input [3:0] o, input [4:0] c, input [14:0] pre, input [14:0] e,
        input [7:0] st, input [7:0] sn, input clr);
        begin
            op = o;
            if (o != 4'h0) begin
                cm = 5'h07;
                pulse(15'h2000);
                sn_m = 8'h0;
                chk(sn_b, par(8'h0));
                chk({8'h0, inv_l}, 9'h0);
                accept;
            end
            cm = c;
            if (pre != 15'h0) begin
                wtx = pre[0];
                pulse(pre);
                chk({8'h0, op_end}, 9'h0);
                chk({8'h0, inv_l}, {8'h0, o[1] & pre[0]});
                chk({8'h0, f0z}, {8'h0, o[2] & pre[1]});
            end
            pulse(e);
            sn_m = clr ? sn : (sn_m | sn);
            chk(st_b, par(st));
            chk(sn_b, par(sn_m));
            if (o != 4'h0)
                chk({8'h0, op_end}, {8'h0, st[3]});
            accept;
            cm = 5'h0;
            wtx = 1'b0;
            n = n + 1;
            $display("test %0d done", n);
        end
    endtask
    // Let a line wait run out and time the ending
    task tmo(input [3:0] o, input [1:0] m, input [31:0] lim);
        begin
            run(o, 5'h0, 15'h0, 15'h0, 8'h0, 8'h0, 1'b0);
            wm = m;
            pulse(15'h4000);
            k = 0;
            while (op_end !== 1'b1 && k < 200) begin
                tick;
                k = k + 1;
            end
            chk({8'h0, k >= lim - 1 && k <= lim + 3}, 9'h1);
            chk(st_b, par(E | C));
            sn_m = sn_m | 8'h02;
            chk(sn_b, par(sn_m));
            wm = 2'h0;
            accept;
            n = n + 1;
            $display("test %0d done", n);
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        repeat (4) tick;
        run(4'h1, 0, 0, 15'h0004, M | E | C, 8'h08, 0);
        run(4'h1, 0, 0, 15'h0002, E | C, 8'h08, 0);
        run(4'h4, 0, 0, 15'h0008, E | C, 8'h40, 0);
        run(4'h2, 0, 0, 15'h0010, E | C, 8'h10, 0);
        run(4'h0, 5'h01, 0, 15'h2000, C, 8'h80, 1);
        run(4'h0, 5'h06, 0, 15'h2001, C, 8'h20, 1);
        run(4'h4, 0, 0, 15'h0020, E | C, 8'h04, 0);
        run(4'h2, 0, 0, 15'h0040, E | C, 8'h01, 0);
        run(4'h4, 0, 0, 15'h0080, E | C, 8'h01, 0);
        run(4'h4, 0, 0, 15'h0100, M | E | X, 8'h00, 0);
        run(4'h2, 0, 0, 15'h0200, E | X, 8'h00, 0);
        run(4'h1, 0, 0, 15'h0400, E | X, 8'h00, 0);
        run(4'h1, 0, 0, 15'h0001, E | C, 8'h20, 0);
        run(4'h2, 0, 15'h0001, 15'h0800, E | C, 8'h20, 0);
        run(4'h4, 0, 15'h0002, 15'h0800, E | C, 8'h08, 0);
        run(4'h0, 5'h0b, 0, 15'h2000, E, 8'h00, 0);
        run(4'h0, 5'h10, 0, 15'h1000, E, 8'h00, 0);
        run(4'h8, 0, 0, 15'h0800, E, 8'h00, 0);
        rs = xs(rs);
        pin = rs[0];
        run(4'h1, 0, 0, 15'h0800, M | E, 8'h00, 0);
        chk({8'h0, nxt_wr}, {8'h0, ~pin});
        tmo(4'h1, 2'h1, SC);
        tmo(4'h4, 2'h2, LC);
        for (k = 0; k < 16; k = k + 1) begin
            tick;
            rs = xs(rs);
            req = rs[15:0];
            #1;
            chk({8'h0, grant}, {8'h0, req[5] && req[4:0] == 5'h0});
        end
        n = n + 1;
        $display("test %0d done", n);
        close_out;
    end
    // Watchdog against a hang
    initial begin
        #(40 * 5000);
        failures = failures + 1;
        close_out;
    end
endmodule
